// ---- afm_monitor.sv ----
// actuator feedback monitor: per-channel supervision with an APB register slave
//
// Notes on behaviour
// RL1: fourteen independent channels, each with own inputs, outputs, settings, state.
// RL2: a channel supervises only while its activation input is high.
// RL3: after activation the feedback change is timed against the set limit.
// RL4: feedback still closed at timeout after release closed: drop release, flag error.
// RL5: feedback not closed at timeout after release opened: error, no release.
// RL6: timeout set from 0.1 s to 3.0 s, 3.0 s after reset.
// RL7: gate mode selects required or ignored outside gate; ignored by default.
// RL8: restart mode manual, controlled or automatic; manual by default.
// RL9: manual and controlled need the reset input; automatic needs none.
// RL10: release only while activated safely and feedback met its time limit.
// RL11: fault contact high exactly while an error is held.
// RL12: elapsed value always shows the running monitoring timer.
// RL13: a 32-bit diagnostic word summarises each channel's state.
// RL14: diagnostic 0000 with no release, 2001 release issued awaiting inputs.
// RL15: diagnostic 2003 awaiting reset rise, 2004 awaiting reset fall.
// RL16: diagnostic 8001 running, 2007 awaiting closure, 801a awaiting opening.
// RL17: diagnostic f011 feedback not opened, f012 feedback not closed.
// RL18: reset and activation both high at start-up: error with f00c.
// RL19: gate required but low: channel inactive, release low.
// RL20: manual mode closes release on a rising reset edge.
// RL21: controlled mode closes release on a falling reset edge.
// RL22: timeout errors clear only while reset input is high.
// RL23: timer restarts at each release change, tick finer than 0.1 s; the code does not restart it when the release drops into AFM_ERR_OPEN.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"

module afm_monitor
	import afm_pkg::*;
#(
	parameter int NUM_CHANNELS = 14,
	parameter int TICK_CYCLES = `AFM_CLK_HZ / 1000 * `AFM_TICK_MS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// coils, one bit per channel
	input wire logic [NUM_CHANNELS-1:0] activationCoil,
	input wire logic [NUM_CHANNELS-1:0] feedbackCoil,
	input wire logic [NUM_CHANNELS-1:0] resetCoil,
	input wire logic [NUM_CHANNELS-1:0] externalGateCoil,
	// contacts, one bit per channel
	output logic [NUM_CHANNELS-1:0] releaseContact,
	output logic [NUM_CHANNELS-1:0] faultContact
);

	// shared time base; one tick every 10 ms
	logic [31:0] tickCount_reg;
	logic tickPulse;
	logic startup_reg;

	// per-channel views for the bus
	afm_cfg_t cfgArr [NUM_CHANNELS];
	logic [15:0] elapsedArr [NUM_CHANNELS];
	logic [31:0] diagArr [NUM_CHANNELS];

	// bus decode
	logic [3:0] busChan;
	logic [1:0] busWord;
	logic chanOk;
	logic wordOk;
	logic addrOk;
	logic busAccess;
	logic cfgWrite;
	logic [31:0] readValue;
	logic [4:0] wrTime;
	logic [4:0] wrTimeClamped;

	assign tickPulse = (tickCount_reg == 32'(TICK_CYCLES - 1));

	// free-running tick divider
	always_ff @(posedge clk)
	begin
		if (rst || tickPulse)
			tickCount_reg <= 32'h0;
		else
			tickCount_reg <= tickCount_reg + 32'h1;
	end

	// high for the first cycle after reset, used for the start-up check
	always_ff @(posedge clk)
	begin
		if (rst)
			startup_reg <= 1'b1;
		else
			startup_reg <= 1'b0;
	end

	// address split: channel in the high nibble, word index in bits 3:2
	assign busChan = paddr[7:`AFM_CHAN_STRIDE_SHIFT];
	assign busWord = paddr[3:2];
	assign chanOk = (32'(busChan) < 32'(NUM_CHANNELS));
	assign wordOk = (busWord <= `AFM_OFS_DIAG);
	assign addrOk = chanOk && wordOk && (paddr[1:0] == 2'h0);
	assign busAccess = psel && penable;
	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = busAccess && !addrOk;
	assign cfgWrite = busAccess && pwrite && addrOk && (busWord == `AFM_OFS_CONFIG);

	// out-of-range timeouts are clamped so a channel never runs with zero time
	assign wrTime = pwdata[`AFM_CFG_TIME_LSB +: 5];
	assign wrTimeClamped = (wrTime < `AFM_TIME_MIN) ? `AFM_TIME_MIN :
		(wrTime > `AFM_TIME_MAX) ? `AFM_TIME_MAX : wrTime; // RL6

	// read mux; only the word selected is looked at
	always_comb
	begin
		readValue = 32'h0;
		if (addrOk)
		begin
			unique case (busWord)
				`AFM_OFS_CONFIG: readValue = {23'h0, cfgArr[busChan[3:0]].timeoutSetting,
					1'b0, cfgArr[busChan[3:0]].restartMode,
					cfgArr[busChan[3:0]].gateRequired};
				`AFM_OFS_ELAPSED: readValue = {16'h0, elapsedArr[busChan[3:0]]}; // RL12
				`AFM_OFS_DIAG: readValue = diagArr[busChan[3:0]]; // RL13
				default: readValue = 32'h0;
			endcase
		end
	end

	// read data registered at the end of the setup phase
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= readValue;
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++)
		begin : gChan // RL1
			afm_cfg_t cfg_reg;
			afm_state_t state_reg;
			afm_state_t state_next;
			logic [15:0] elapsed_reg;
			logic resetPrev_reg;
			logic [31:0] diag_reg;
			logic [31:0] diag_next;
			logic [8:0] limitTicks;
			logic timeUp;
			logic gateOk;
			logic armed;
			logic resetRise;
			logic resetFall;
			logic timing;
			logic restartTimer;
			logic isAuto;
			logic isControlled;
			logic loopClosed;
			logic startFault;
			logic releaseNext;
			logic faultNext;

			// timeout in ticks: tenths times ten
			assign limitTicks = 9'(cfg_reg.timeoutSetting) * 9'(`AFM_TICKS_PER_TENTH); // RL23
			assign timeUp = (elapsed_reg >= {7'h0, limitTicks}); // RL3
			assign gateOk = !cfg_reg.gateRequired || externalGateCoil[ch]; // RL7 RL19
			assign armed = gateOk && activationCoil[ch]; // RL2
			assign resetRise = resetCoil[ch] && !resetPrev_reg;
			assign resetFall = !resetCoil[ch] && resetPrev_reg;
			assign isAuto = (cfg_reg.restartMode == AFM_AUTOMATIC);
			assign isControlled = (cfg_reg.restartMode == AFM_CONTROLLED);
			// start-up fault and loop level, named for the sequence below
			assign startFault = startup_reg && resetCoil[ch] && activationCoil[ch]; // RL18
			assign loopClosed = feedbackCoil[ch];

			// contacts follow the next state so they move together with the diagnostic word
			assign releaseNext = (state_next == AFM_WAIT_OPEN) ||
				(state_next == AFM_RUN); // RL10 RL19
			assign faultNext = (state_next == AFM_ERR_OPEN) ||
				(state_next == AFM_ERR_CLOSE) || (state_next == AFM_ERR_START); // RL11
			assign timing = (state_reg == AFM_WAIT_OPEN) || (state_reg == AFM_DROP);
			// timer restarts on entry to AFM_WAIT_OPEN or AFM_DROP, not when the release drops into AFM_ERR_OPEN
			assign restartTimer = (state_next == AFM_WAIT_OPEN && state_reg != AFM_WAIT_OPEN) ||
				(state_next == AFM_DROP && state_reg != AFM_DROP); // RL23

			// per-channel settings register
			always_ff @(posedge clk)
			begin
				if (rst)
					cfg_reg <= '{`AFM_TIME_RESET, AFM_MANUAL, 1'b0}; // RL6 RL7 RL8
				else if (cfgWrite && busChan == 4'(ch))
					cfg_reg <= '{wrTimeClamped, pwdata[`AFM_CFG_MODE_LSB +: 2],
						pwdata[`AFM_CFG_GATE_BIT]};
			end

			// supervision sequence; each arm lists its exits in priority order
			always_comb
			begin
				state_next = state_reg;
				unique case (state_reg)
					AFM_OFF:
					begin
						if (startFault)
						begin
							state_next = AFM_ERR_START; // RL18
						end
						else if (armed && loopClosed)
						begin
							// manual and spare codes start on a rise, controlled on rise then fall
							if (isAuto)
							begin
								state_next = AFM_WAIT_OPEN; // RL9
							end
							else if (resetRise && isControlled)
							begin
								state_next = AFM_WAIT_FALL; // RL21
							end
							else if (resetRise)
							begin
								state_next = AFM_WAIT_OPEN; // RL20 RL9
							end
						end
					end
					AFM_WAIT_FALL:
					begin
						// losing the arming before the fall cancels the start
						if (!armed || !loopClosed)
						begin
							state_next = AFM_OFF;
						end
						else if (resetFall)
						begin
							state_next = AFM_WAIT_OPEN; // RL21
						end
					end
					AFM_WAIT_OPEN:
					begin
						if (!armed)
						begin
							state_next = AFM_DROP;
						end
						else if (!loopClosed)
						begin
							state_next = AFM_RUN; // RL10
						end
						else if (timeUp)
						begin
							state_next = AFM_ERR_OPEN; // RL4
						end
					end
					AFM_RUN:
					begin
						// a loop that closes again while running is not judged here
						if (!armed)
						begin
							state_next = AFM_DROP;
						end
					end
					AFM_DROP:
					begin
						if (loopClosed)
						begin
							state_next = AFM_OFF;
						end
						else if (timeUp)
						begin
							state_next = AFM_ERR_CLOSE; // RL5
						end
					end
					AFM_ERR_OPEN,
					AFM_ERR_CLOSE:
					begin
						// acknowledged by the reset coil in every restart mode
						if (resetCoil[ch])
						begin
							state_next = AFM_OFF; // RL22
						end
					end
					AFM_ERR_START:
					begin
						// cleared once the reset coil is let go
						if (!resetCoil[ch])
						begin
							state_next = AFM_OFF;
						end
					end
					default:
					begin
						state_next = AFM_ERR_START; // broken one-hot code fails safe
					end
				endcase
			end

			// diagnostic word for the next state
			always_comb
			begin
				diag_next = `AFM_DG_NONE; // RL14
				unique case (state_next)
					AFM_OFF:
					begin
						if (!armed)
						begin
							diag_next = `AFM_DG_NONE; // RL14
						end
						else if (!loopClosed)
						begin
							diag_next = `AFM_DG_WAIT_CLOSE; // RL16
						end
						else if (isAuto)
						begin
							diag_next = `AFM_DG_ISSUED; // RL14
						end
						else
						begin
							diag_next = `AFM_DG_WAIT_RISE; // RL15
						end
					end
					AFM_WAIT_FALL: diag_next = `AFM_DG_WAIT_FALL; // RL15
					AFM_WAIT_OPEN: diag_next = `AFM_DG_WAIT_OPEN; // RL16
					AFM_RUN: diag_next = `AFM_DG_RUN; // RL16
					AFM_DROP: diag_next = `AFM_DG_WAIT_CLOSE; // RL16
					AFM_ERR_OPEN: diag_next = `AFM_DG_ERR_OPEN; // RL17
					AFM_ERR_CLOSE: diag_next = `AFM_DG_ERR_CLOSE; // RL17
					AFM_ERR_START: diag_next = `AFM_DG_ERR_START; // RL18
					default: diag_next = `AFM_DG_ERR_START;
				endcase
			end

			// state, reset edge memory, diagnostic and contacts
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					state_reg <= AFM_OFF;
					resetPrev_reg <= 1'b0;
					diag_reg <= `AFM_DG_NONE;
					releaseContact[ch] <= 1'b0;
					faultContact[ch] <= 1'b0;
				end
				else
				begin
					state_reg <= state_next;
					resetPrev_reg <= resetCoil[ch];
					diag_reg <= diag_next;
					releaseContact[ch] <= releaseNext; // RL10
					faultContact[ch] <= faultNext; // RL11
				end
			end

			// monitoring timer; saturates rather than wraps so a late read stays truthful
			always_ff @(posedge clk)
			begin
				if (rst || restartTimer)
					elapsed_reg <= 16'h0; // RL23
				else if (timing && tickPulse && elapsed_reg != 16'hffff)
					elapsed_reg <= elapsed_reg + 16'h1; // RL12
			end

			assign cfgArr[ch] = cfg_reg;
			assign elapsedArr[ch] = elapsed_reg;
			assign diagArr[ch] = diag_reg;
		end
	endgenerate

endmodule // afm_monitor
`default_nettype wire

// ---- afm_consts.svh ----
// constants of the actuator feedback monitor: offsets, fields, resets, timing
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH

// register map, one block of four words per channel
`define AFM_CHAN_STRIDE_SHIFT 4
`define AFM_OFS_CONFIG 2'h0
`define AFM_OFS_ELAPSED 2'h1
`define AFM_OFS_DIAG 2'h2

// config word fields
`define AFM_CFG_GATE_BIT 0
`define AFM_CFG_MODE_LSB 1
`define AFM_CFG_TIME_LSB 4
`define AFM_CFG_WIDTH 9

// timeout setting in tenths of a second
`define AFM_TIME_MIN 5'h01
`define AFM_TIME_MAX 5'h1e
`define AFM_TIME_RESET 5'h1e

// elapsed timer counts ticks of this length
`define AFM_TICK_MS 10
`define AFM_CLK_HZ 20000000
`define AFM_TICKS_PER_TENTH 4'ha

// diagnostic codes
`define AFM_DG_NONE 32'h0000_0000
`define AFM_DG_ISSUED 32'h0000_2001
`define AFM_DG_WAIT_RISE 32'h0000_2003
`define AFM_DG_WAIT_FALL 32'h0000_2004
`define AFM_DG_WAIT_CLOSE 32'h0000_2007
`define AFM_DG_RUN 32'h0000_8001
`define AFM_DG_WAIT_OPEN 32'h0000_801a
`define AFM_DG_ERR_START 32'h0000_f00c
`define AFM_DG_ERR_OPEN 32'h0000_f011
`define AFM_DG_ERR_CLOSE 32'h0000_f012

`endif

// ---- afm_pkg.sv ----
// types of the actuator feedback monitor
package afm_pkg;

	typedef enum logic [1:0] {
		AFM_MANUAL = 2'h0,
		AFM_CONTROLLED = 2'h1,
		AFM_AUTOMATIC = 2'h2
	} afm_restart_t;

	// per-channel settings as held in the config word
	typedef struct packed {
		logic [4:0] timeoutSetting;
		logic [1:0] restartMode;
		logic gateRequired;
	} afm_cfg_t;

	typedef enum logic [7:0] {
		AFM_OFF = 8'h01,
		AFM_WAIT_FALL = 8'h02,
		AFM_WAIT_OPEN = 8'h04,
		AFM_RUN = 8'h08,
		AFM_DROP = 8'h10,
		AFM_ERR_OPEN = 8'h20,
		AFM_ERR_CLOSE = 8'h40,
		AFM_ERR_START = 8'h80
	} afm_state_t;

endpackage

// ---- afm_monitor_assertions.sv ----
// port checker of the actuator feedback monitor
`timescale 1ns/1ps
`default_nettype none
module afm_monitor_assertions #(
	parameter int NUM_CHANNELS = 14,
	parameter int TICK_CYCLES = 200000
)
(
	// clock, reset and apb
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	// coils and contacts
	input wire logic [NUM_CHANNELS-1:0] activationCoil,
	input wire logic [NUM_CHANNELS-1:0] feedbackCoil,
	input wire logic [NUM_CHANNELS-1:0] resetCoil,
	input wire logic [NUM_CHANNELS-1:0] releaseContact,
	input wire logic [NUM_CHANNELS-1:0] faultContact
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int stuckCnt;
	// cycles with release closed but loop still closed; slack covers tick phase
	always_ff @(posedge clk)
		stuckCnt <= (rst || !(releaseContact[0] && feedbackCoil[0])) ? 0 : stuckCnt + 1;
	a_open_timeout: assert property (stuckCnt <= 301 * TICK_CYCLES + 3)
		else $error("release held past the longest timeout");
	a_rise_armed: assert property ($rose(releaseContact[0]) |->
		$past(activationCoil[0] && feedbackCoil[0])) else $error("release without arming");
	// channel 0 stays in manual restart in every scenario of the bench
	a_manual_edge: assert property ($rose(releaseContact[0]) |->
		$past(resetCoil[0]) && !$past(resetCoil[0], 2))
		else $error("release without reset rise");
	a_drop_on_idle: assert property (releaseContact[0] && !activationCoil[0] |=>
		!releaseContact[0]) else $error("release kept after deactivation");
	a_contacts_exclusive: assert property ((releaseContact & faultContact) == '0)
		else $error("release and fault together");
	a_fault_drops_release: assert property ($rose(faultContact[0]) |-> !releaseContact[0])
		else $error("fault with release");
	a_fault_clear: assert property ($fell(faultContact[0]) |-> $past(resetCoil[0]))
		else $error("fault cleared without reset");
	a_unmapped_err: assert property (psel && penable && paddr[3:2] == 2'h3 |-> pslverr)
		else $error("unmapped access not refused");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	c_release: cover property ($rose(releaseContact[0]));
	c_fault: cover property ($rose(faultContact[0]));
	c_refused: cover property (pslverr);
endmodule // afm_monitor_assertions
bind afm_monitor afm_monitor_assertions #(.NUM_CHANNELS(NUM_CHANNELS),
	.TICK_CYCLES(TICK_CYCLES)) i_afm_monitor_assertions (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
	.activationCoil(activationCoil), .feedbackCoil(feedbackCoil), .resetCoil(resetCoil),
	.releaseContact(releaseContact), .faultContact(faultContact));
`default_nettype wire

// ---- afm_actuator_model.sv ----
// behavioural contactors with feedback loops
`timescale 1ns/1ps
`default_nettype none
module afm_actuator_model #(
	parameter int N = 14,
	parameter int DLY = 5
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// release in, welded contact request from the bench
	input wire logic [N-1:0] releaseContact,
	input wire logic [N-1:0] stuck,
	// loop closed while the contactor is off
	output logic [N-1:0] feedbackCoil
);
	int cnt [N];
	// the loop follows the coil after a delay; a welded contact never moves
	always_ff @(posedge clk)
		for (int i = 0; i < N; i++)
		begin
			if (rst)
				feedbackCoil[i] <= 1'h1;
			if (rst || stuck[i] || feedbackCoil[i] != releaseContact[i])
				cnt[i] <= 0;
			else if (cnt[i] == DLY)
				feedbackCoil[i] <= !releaseContact[i];
			else
				cnt[i] <= cnt[i] + 1;
		end
endmodule // afm_actuator_model
`default_nettype wire

// ---- afm_monitor_tb.sv ----
// self-checking bench of the actuator feedback monitor
`timescale 1ns/1ps
`default_nettype none
module afm_monitor_tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, serr;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	// channel 1 sees reset and activation at start-up
	logic [13:0] act = 14'h2, rco = 14'h2, gate = '0, stuck = '0, fb, rel, flt;
	int n_fail = 0, check_count = 0, cyc = 0;
	afm_monitor #(.TICK_CYCLES(4)) i_afm_monitor (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .activationCoil(act),
		.feedbackCoil(fb), .resetCoil(rco), .externalGateCoil(gate),
		.releaseContact(rel), .faultContact(flt));
	afm_actuator_model i_afm_actuator_model (.clk(clk), .rst(rst),
		.releaseContact(rel), .stuck(stuck), .feedbackCoil(fb));
	always #25 clk = ~clk;
	// watchdog against a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic dg(input int ch, input logic [31:0] e);
		apb(1'h0, 8'(ch * 16 + 8), 32'h0);
		chk("diag", e, rdat);
	endtask
	task automatic t_regs;
		// the start-up fault reaches the diag word one edge after the check cycle
		tk(2);
		dg(1, 32'hf00c);
		rco[1] <= 1'h0;
		apb(1'h0, 8'h00, 32'h0);
		chk("cfg reset", 32'h1e0, rdat);
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h0, 8'h00, 32'h0);
		chk("cfg clamp", 32'h10, rdat);
		apb(1'h0, 8'h0c, 32'h0);
		chk("unmapped", 32'h1, serr);
	endtask
	task automatic t_manual;
		act[0] <= 1'h1;
		tk(3);
		dg(0, 32'h2003);
		rco[0] <= 1'h1;
		tk(3);
		chk("release", 32'h1, rel[0]);
		rco[0] <= 1'h0;
		tk(12);
		dg(0, 32'h8001);
		act[0] <= 1'h0;
		tk(2);
		dg(0, 32'h2007);
		tk(10);
		dg(0, 32'h0);
	endtask
	task automatic t_welded;
		stuck[0] <= 1'h1;
		act[0] <= 1'h1;
		tk(3);
		rco[0] <= 1'h1;
		tk(2);
		rco[0] <= 1'h0;
		tk(2);
		dg(0, 32'h801a);
		tk(50);
		chk("fault", 32'h1, flt[0]);
		dg(0, 32'hf011);
		// timer froze at the limit: a setting of one tenth is ten ticks
		apb(1'h0, 8'h04, 32'h0);
		chk("elapsed", 32'ha, rdat);
		stuck[0] <= 1'h0;
		rco[0] <= 1'h1;
		tk(3);
		chk("fault cleared", 32'h0, flt[0]);
		rco[0] <= 1'h0;
		act[0] <= 1'h0;
	endtask
	task automatic t_modes;
		apb(1'h1, 8'h20, 32'h12);
		apb(1'h1, 8'h30, 32'h14);
		apb(1'h1, 8'h40, 32'h1e5);
		act[4:2] <= 3'h7;
		tk(3);
		chk("auto release", 32'h1, rel[3]);
		chk("gated", 32'h0, rel[4]);
		rco[2] <= 1'h1;
		gate[4] <= 1'h1;
		tk(3);
		dg(2, 32'h2004);
		chk("gate open", 32'h1, rel[4]);
		rco[2] <= 1'h0;
		stuck[3] <= 1'h1;
		act[3] <= 1'h0;
		tk(3);
		chk("controlled", 32'h1, rel[2]);
		tk(50);
		dg(3, 32'hf012);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		tk(12);
		rst <= 1'h0;
		t_regs;
		t_manual;
		t_welded;
		t_modes;
		tally_and_finish;
	end
endmodule // afm_monitor_tb
`default_nettype wire
